// file: rtl/gpsc_pkg.sv
// Package with offsets, field positions, reset values and carrier types for the block.
package gpsc_pkg;

  // Configuration byte offsets.
  localparam logic [7:0]  PWRCTL_OFFSET    = 8'hd4;
  localparam logic [7:0]  SWEVT_OFFSET     = 8'he0;
  localparam logic [7:0]  CLKGATE_OFFSET   = 8'hf0;

  // Reset values.
  localparam logic [15:0] PWRCTL_RESET     = 16'h0000;
  localparam logic [15:0] SWEVT_RESET      = 16'h0000;
  localparam logic [15:0] CLKGATE_RESET    = 16'h1606;

  // Field positions.
  localparam int          EVT_SEL_BIT      = 15;
  localparam int          SCI_TRIG_BIT     = 0;
  localparam int          CLK_GATE_BIT     = 14;

  // Writable mask of the clock gating register; other bits are read-only zero.
  localparam logic [15:0] CLKGATE_WMASK    = 16'h5f7f;

  // Power state encodings.
  localparam logic [1:0]  PWR_D0           = 2'h0;
  localparam logic [1:0]  PWR_D3           = 2'h3;

  // Duration of the graphics reset pulse on the D3 to D0 change, in cycles.
  localparam int          GFX_RESET_CYCLES = 4;

  // One configuration access from the host.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
    logic [1:0]  byte_en;
    logic [15:0] wdata;
  } gpsc_cfg_req_t;

  // Answer to a configuration access.
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } gpsc_cfg_rsp_t;

  // Sequencer state for the SCI message.
  typedef enum logic [1:0] {
    SCI_IDLE = 2'b00,
    SCI_SEND = 2'b01,
    SCI_WAIT = 2'b11
  } gpsc_sci_state_t;

endpackage

// file: rtl/gpsc_sci_sender.sv
// Sends SCI messages over the hub link on request pulses; pulses arriving while a message is in flight queue only one more.
`timescale 1ns/1ps
module gpsc_sci_sender (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Request from the register bank.
  input  wire logic sci_request,
  // Hub link message handshake.
  output logic      hub_sci_valid,
  input  wire logic hub_sci_ready
);

  gpsc_pkg::gpsc_sci_state_t state_q;
  gpsc_pkg::gpsc_sci_state_t state_d;
  logic                      pend_q;
  logic                      pend_d;

  always_comb begin
    state_d = state_q;
    pend_d  = pend_q | sci_request;
    unique case (state_q)
      gpsc_pkg::SCI_IDLE: begin
        if (pend_d) begin
          state_d = gpsc_pkg::SCI_SEND;
          pend_d  = 1'b0;
        end
      end
      gpsc_pkg::SCI_SEND: begin
        if (hub_sci_ready) begin
          state_d = gpsc_pkg::SCI_WAIT;
        end
      end
      gpsc_pkg::SCI_WAIT: begin
        state_d = gpsc_pkg::SCI_IDLE;
      end
      default: begin
        state_d = gpsc_pkg::SCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q       <= gpsc_pkg::SCI_IDLE;
      pend_q        <= 1'b0;
      hub_sci_valid <= 1'b0;
    end else begin
      state_q       <= state_d;
      pend_q        <= pend_d;
      hub_sci_valid <= (state_d == gpsc_pkg::SCI_SEND);
    end
  end

endmodule

// file: rtl/gpsc_regs.sv
// Power state, software event and clock gating configuration registers.
`timescale 1ns/1ps
module gpsc_regs (
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  // Configuration access.
  input  wire gpsc_pkg::gpsc_cfg_req_t cfg_req,
  output gpsc_pkg::gpsc_cfg_rsp_t      cfg_rsp,
  // Hub link SCI message.
  output logic                         hub_sci_valid,
  input  wire logic                    hub_sci_ready,
  // Block controls.
  output logic [1:0]                   power_state_field,
  output logic                         gfx_reset,
  output logic                         display_core_clock_gate,
  output logic                         smi_trigger
);

  logic [1:0]  pwr_q;
  logic [1:0]  pwr_d;
  logic [15:0] swevt_q;
  logic [15:0] swevt_d;
  logic [15:0] clkg_q;
  logic [15:0] clkg_d;
  logic [2:0]  rst_cnt_q;
  logic [2:0]  rst_cnt_d;
  logic        sci_req;
  logic        smi_d;
  logic [15:0] rdata_d;
  logic        wr;

  // Merge write data into a register under byte enables and a writable mask.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] wm);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction

  assign wr = cfg_req.valid & cfg_req.write;

  always_comb begin
    pwr_d     = pwr_q;
    swevt_d   = swevt_q;
    clkg_d    = clkg_q;
    rst_cnt_d = (rst_cnt_q != 3'h0) ? rst_cnt_q - 3'h1 : 3'h0;
    sci_req   = 1'b0;
    smi_d     = 1'b0;
    if (wr && cfg_req.offset == gpsc_pkg::PWRCTL_OFFSET && cfg_req.byte_en[0]) begin
      if (cfg_req.wdata[1:0] == gpsc_pkg::PWR_D0 ||
          cfg_req.wdata[1:0] == gpsc_pkg::PWR_D3) begin
        pwr_d = cfg_req.wdata[1:0];
        if (pwr_q == gpsc_pkg::PWR_D3 && cfg_req.wdata[1:0] == gpsc_pkg::PWR_D0) begin
          rst_cnt_d = 3'(gpsc_pkg::GFX_RESET_CYCLES);
        end
      end
    end
    if (wr && cfg_req.offset == gpsc_pkg::SWEVT_OFFSET) begin
      swevt_d = merge(swevt_q, cfg_req.wdata, cfg_req.byte_en, 16'hffff);
      if (swevt_d[gpsc_pkg::EVT_SEL_BIT]) begin
        sci_req = swevt_d[gpsc_pkg::SCI_TRIG_BIT] & ~swevt_q[gpsc_pkg::SCI_TRIG_BIT];
      end else begin
        smi_d = cfg_req.byte_en[0];
      end
    end
    if (wr && cfg_req.offset == gpsc_pkg::CLKGATE_OFFSET) begin
      clkg_d = merge(clkg_q, cfg_req.wdata, cfg_req.byte_en, gpsc_pkg::CLKGATE_WMASK);
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    unique case (cfg_req.offset)
      gpsc_pkg::PWRCTL_OFFSET:  rdata_d = {14'h0000, pwr_q};
      gpsc_pkg::SWEVT_OFFSET:   rdata_d = swevt_q;
      gpsc_pkg::CLKGATE_OFFSET: rdata_d = clkg_q;
      default:                  rdata_d = 16'h0000;
    endcase
  end

  // The trigger bit is left alone after the message; re-arming is software's job.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pwr_q                   <= gpsc_pkg::PWRCTL_RESET[1:0];
      swevt_q                 <= gpsc_pkg::SWEVT_RESET;
      clkg_q                  <= gpsc_pkg::CLKGATE_RESET;
      rst_cnt_q               <= 3'h0;
      cfg_rsp                 <= '0;
      power_state_field       <= gpsc_pkg::PWRCTL_RESET[1:0];
      gfx_reset               <= 1'b0;
      display_core_clock_gate <= gpsc_pkg::CLKGATE_RESET[gpsc_pkg::CLK_GATE_BIT];
      smi_trigger             <= 1'b0;
    end else begin
      pwr_q                   <= pwr_d;
      swevt_q                 <= swevt_d;
      clkg_q                  <= clkg_d;
      rst_cnt_q               <= rst_cnt_d;
      cfg_rsp.ack             <= cfg_req.valid;
      cfg_rsp.rdata           <= cfg_req.valid && !cfg_req.write ? rdata_d : 16'h0000;
      power_state_field       <= pwr_d;
      gfx_reset               <= (rst_cnt_d != 3'h0);
      display_core_clock_gate <= clkg_d[gpsc_pkg::CLK_GATE_BIT];
      smi_trigger             <= smi_d;
    end
  end

  gpsc_sci_sender u_sci (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .sci_request   (sci_req),
    .hub_sci_valid (hub_sci_valid),
    .hub_sci_ready (hub_sci_ready)
  );

endmodule

// file: sim/gpsc_hub_model.sv
// Hub link receiver model that accepts each SCI message after a delay.
`timescale 1ns/1ps
module gpsc_hub_model #(parameter int DELAY = 3) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic hub_sci_valid,
  output logic      hub_sci_ready,
  output int        msg_count
);
  int wait_n;
  always @(posedge sys_clk) begin
    hub_sci_ready <= reset_n && hub_sci_valid && !hub_sci_ready && wait_n == DELAY;
    wait_n <= (reset_n && hub_sci_valid && !hub_sci_ready) ? wait_n + 1 : 0;
    msg_count <= !reset_n ? 0 : msg_count + int'(hub_sci_valid && hub_sci_ready);
  end
endmodule

// file: sim/gpsc_regs_chk.sv
// Assertion checker for the configuration register block.
`timescale 1ns/1ps
module gpsc_regs_chk (
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  input wire gpsc_pkg::gpsc_cfg_req_t cfg_req,
  input wire gpsc_pkg::gpsc_cfg_rsp_t cfg_rsp,
  input wire logic                    hub_sci_valid,
  input wire logic                    hub_sci_ready,
  input wire logic [1:0]              power_state_field,
  input wire logic                    gfx_reset,
  input wire logic                    display_core_clock_gate,
  input wire logic                    smi_trigger
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic pw;
  assign pw = cfg_req.valid && cfg_req.write && cfg_req.offset == 8'hd4 && cfg_req.byte_en[0];
  property p_ack; cfg_req.valid |=> cfg_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pok; pw && cfg_req.wdata[1] == cfg_req.wdata[0] |=> power_state_field == $past(cfg_req.wdata[1:0]); endproperty
  a_pok: assert property (p_pok) else $error("state write lost");
  property p_pbad; pw && cfg_req.wdata[1] != cfg_req.wdata[0] |=> $stable(power_state_field); endproperty
  a_pbad: assert property (p_pbad) else $error("bad state taken");
  property p_gfx; $rose(gfx_reset) |-> gfx_reset [*4] ##1 !gfx_reset; endproperty
  a_gfx: assert property (p_gfx) else $error("reset pulse length");
  property p_hold; hub_sci_valid && !hub_sci_ready |=> hub_sci_valid; endproperty
  a_hold: assert property (p_hold) else $error("message dropped");
  property p_gate; cfg_req.valid && cfg_req.write && cfg_req.offset == 8'hf0 && cfg_req.byte_en[1] |=> display_core_clock_gate == $past(cfg_req.wdata[14]); endproperty
  a_gate: assert property (p_gate) else $error("gate bit");
  property p_ro; cfg_req.valid && !cfg_req.write && cfg_req.offset == 8'hf0 |=> (cfg_rsp.rdata & 16'ha080) == 16'h0000; endproperty
  a_ro: assert property (p_ro) else $error("reserved bit set");
  property p_smi; smi_trigger |-> $past(cfg_req.valid && cfg_req.write && cfg_req.offset == 8'he0 && !cfg_req.wdata[15]); endproperty
  a_smi: assert property (p_smi) else $error("stray smi");
endmodule

// file: sim/tb.sv
// Testbench for the configuration register block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
  typedef struct packed {logic [7:0] off; logic [1:0] be; logic [15:0] wd; logic [15:0] rd;} gpsc_row_t;
  logic                    sys_clk = 0;
  logic                    reset_n = 0;
  gpsc_pkg::gpsc_cfg_req_t cfg_req = '0;
  gpsc_pkg::gpsc_cfg_rsp_t cfg_rsp;
  logic                    hub_sci_valid, hub_sci_ready, gfx_reset, display_core_clock_gate, smi_trigger;
  logic [1:0]              power_state_field;
  logic [15:0]             rd;
  int                      bad_count = 0, total_checks = 0, cyc = 0, msg_count;
  int                      smi_count = 0, gfx_count = 0;
  gpsc_row_t               rows [8] = '{'{8'he0, 2'h3, 16'h7ffe, 16'h7ffe}, '{8'hf0, 2'h3, 16'hffff, 16'h5f7f},
    '{8'hf0, 2'h2, 16'h0000, 16'h007f}, '{8'hd4, 2'h1, 16'h0003, 16'h0003}, '{8'hd4, 2'h1, 16'h0001, 16'h0003},
    '{8'hd4, 2'h1, 16'h0002, 16'h0003}, '{8'hd4, 2'h1, 16'h0000, 16'h0000}, '{8'h44, 2'h3, 16'hffff, 16'h0000}};
  gpsc_regs dut_u (.*);
  gpsc_hub_model hub_u (.sys_clk(sys_clk), .reset_n(reset_n), .hub_sci_valid(hub_sci_valid),
    .hub_sci_ready(hub_sci_ready), .msg_count(msg_count));
  always #5 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One access: request held for one edge, answer read one cycle later.
  task automatic acc(input logic w, input logic [7:0] o, input logic [15:0] d, input logic [1:0] b);
    @(posedge sys_clk) cfg_req <= '{1'b1, w, o, b, d};
    @(posedge sys_clk) cfg_req.valid <= 1'b0;
    #1 rd = cfg_rsp.rdata;
    `CHK("ack", 1'b1, cfg_rsp.ack)
  endtask
  always @(posedge sys_clk) begin
    if (reset_n && smi_trigger === 1'b1) smi_count++;
    if (reset_n && gfx_reset === 1'b1) gfx_count++;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      acc(1'b1, rows[i].off, rows[i].wd, rows[i].be);
      acc(1'b0, rows[i].off, 16'h0000, 2'h3);
      `CHK("row", rows[i].rd, rd)
    end
    acc(1'b1, 8'he0, 16'h8000, 2'h3);
    acc(1'b1, 8'he0, 16'h8001, 2'h3);
    acc(1'b1, 8'he0, 16'h8001, 2'h3);
    acc(1'b0, 8'he0, 16'h0000, 2'h3);
    `CHK("trigger", 16'h8001, rd)
    acc(1'b1, 8'he0, 16'h8000, 2'h3);
    acc(1'b1, 8'he0, 16'h8001, 2'h3);
    repeat (20) @(posedge sys_clk);
    `CHK("msgs", 2, msg_count)
    `CHK("smi pulses", 1, smi_count)
    `CHK("gfx reset cycles", 4, gfx_count)
    @(posedge sys_clk) reset_n <= 1'b0;
    @(posedge sys_clk) reset_n <= 1'b1;
    acc(1'b0, 8'hf0, 16'h0000, 2'h3);
    `CHK("f0 reset", 16'h1606, rd)
    acc(1'b0, 8'he0, 16'h0000, 2'h3);
    `CHK("e0 reset", 16'h0000, rd)
    `CHK("clock gate", 1'b0, display_core_clock_gate)
    `CHK("power state", 2'h0, power_state_field)
    test_done;
  end
endmodule
bind gpsc_regs gpsc_regs_chk chk_u (.*);
